// [rtl/baud_gen.sv]
// Baud generator with prescaler, tx and rx dividers, low-power handling and interrupt registers.
// Assumes synchronous register port, one clock, transmitter and receiver outside the block.
//
// How it works
// - Prescaler divides processor clock by 1, 3, 4 or 13 per select code.
// - Tx and rx dividers each divide prescaler output by two to the power n.
// - Receiver sample tick runs at sixteen times the receive bit rate.
// - Stop mode halts the prescaler and both dividers, so tx and rx stop.
// - Transmission frozen in stop resumes where it was on interrupt exit.
// - Reception in stop stops sampling and remaining character is aborted.
// - Wait mode leaves the generator running normally.
// - An enabled pending interrupt during wait mode raises the wake request.
// - Clearing both enables in control two disables the interface.
// - Bit rate is clock over sixteen times prescaler times divider.
`timescale 1ns/10ps
module baud_gen
  import baud_gen_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire reg_req_s req_in,
  input wire power_mode_e mode_in,
  input wire logic rx_busy_in,
  input wire logic tx_busy_in,
  output logic [7:0] rdata_out,
  output logic tx_tick_out,
  output logic rx_sample_tick_out,
  output logic rx_abort_out,
  output logic tx_enable_out,
  output logic rx_enable_out,
  output logic irq_out,
  output logic wake_out
);
  logic [7:0] rate_reg, rate_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] stat_reg, stat_next;
  logic [7:0] mask_reg, mask_next;
  logic [3:0] pre_cnt_reg;
  logic [6:0] tx_div_reg;
  logic [6:0] rx_div_reg;
  logic [3:0] tx_os_reg;
  logic stop_d_reg;
  wire logic halted = (mode_in == stop_mode);
  wire logic run = clk_en_in && !halted;
  wire logic [1:0] pre_sel = rate_reg[prescale_sel_lo_pos +: 2];
  wire logic [2:0] tx_rate_sel = rate_reg[tx_rate_sel_pos +: 3];
  wire logic [2:0] rx_rate_sel = rate_reg[rx_rate_sel_pos +: 3];
  wire logic [3:0] pre_last = (pre_sel == 2'b00) ? ratio_1 :
                              (pre_sel == 2'b01) ? ratio_3 :
                              (pre_sel == 2'b10) ? ratio_4 : ratio_13;
  wire logic pre_tick = (pre_cnt_reg >= pre_last);
  wire logic [6:0] tx_last = 7'((8'h01 << tx_rate_sel) - 8'h01);
  wire logic [6:0] rx_last = 7'((8'h01 << rx_rate_sel) - 8'h01);
  wire logic tx_div_tick = pre_tick && (tx_div_reg >= tx_last);
  wire logic rx_div_tick = pre_tick && (rx_div_reg >= rx_last);
  wire logic if_on = ctrl_reg[tx_enable_pos] || ctrl_reg[rx_enable_pos];
  wire logic tx_bit = tx_div_tick && (tx_os_reg == rx_oversample_last);
  wire logic stop_entry = halted && !stop_d_reg;
  wire logic [7:0] events = {5'h00, stop_entry && rx_busy_in, tx_bit && ctrl_reg[tx_enable_pos],
                             rx_div_tick && ctrl_reg[rx_enable_pos]};
  wire logic wr_rate = req_in.wr && req_in.addr == rate_reg_addr;
  wire logic wr_ctrl = req_in.wr && req_in.addr == ctrl_two_addr;
  wire logic wr_stat = req_in.wr && req_in.addr == irq_status_addr;
  wire logic wr_mask = req_in.wr && req_in.addr == irq_mask_addr;
  wire logic [7:0] gen_status = {4'h0, tx_busy_in, rx_busy_in, halted, if_on};
  wire logic [7:0] rd_mux = (req_in.addr == rate_reg_addr) ? rate_reg :
                            (req_in.addr == ctrl_two_addr) ? ctrl_reg :
                            (req_in.addr == irq_status_addr) ? stat_reg :
                            (req_in.addr == irq_mask_addr) ? mask_reg :
                            (req_in.addr == gen_status_addr) ? gen_status : 8'h00;
  wire logic irq_level = |(stat_next & mask_next);
  always_comb begin
    rate_next = wr_rate ? req_in.wdata : rate_reg;
    ctrl_next = wr_ctrl ? req_in.wdata : ctrl_reg;
    mask_next = wr_mask ? req_in.wdata : mask_reg;
    // Set wins over write-one-to-clear
    stat_next = ((wr_stat ? (stat_reg & ~req_in.wdata) : stat_reg)) | (run || stop_entry ? events : 8'h00);
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rate_reg <= rate_reg_reset;
      ctrl_reg <= ctrl_two_reset;
      stat_reg <= irq_reset;
      mask_reg <= irq_reset;
      rdata_out <= 8'h00;
      irq_out <= 1'b0;
      wake_out <= 1'b0;
      stop_d_reg <= 1'b0;
      rx_abort_out <= 1'b0;
      tx_enable_out <= 1'b0;
      rx_enable_out <= 1'b0;
    end else if (clk_en_in) begin
      rate_reg <= rate_next;
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      rdata_out <= req_in.rd ? rd_mux : 8'h00;
      irq_out <= irq_level;
      wake_out <= irq_level && (mode_in == wait_mode);
      stop_d_reg <= halted;
      rx_abort_out <= stop_entry && rx_busy_in;
      tx_enable_out <= ctrl_next[tx_enable_pos];
      rx_enable_out <= ctrl_next[rx_enable_pos];
    end
  end
  // Counters hold their value through stop, so a frozen transmission resumes in phase
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pre_cnt_reg <= 4'h0;
      tx_div_reg <= 7'h00;
      rx_div_reg <= 7'h00;
      tx_os_reg <= 4'h0;
    end else if (run) begin
      pre_cnt_reg <= pre_tick ? 4'h0 : pre_cnt_reg + 4'h1;
      if (pre_tick) begin
        tx_div_reg <= tx_div_tick ? 7'h00 : tx_div_reg + 7'h01;
        rx_div_reg <= rx_div_tick ? 7'h00 : rx_div_reg + 7'h01;
      end
      if (tx_div_tick) begin
        tx_os_reg <= tx_os_reg + 4'h1;
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_tick_out <= 1'b0;
      rx_sample_tick_out <= 1'b0;
    end else if (clk_en_in) begin
      tx_tick_out <= run && tx_bit && ctrl_reg[tx_enable_pos];
      rx_sample_tick_out <= run && rx_div_tick && ctrl_reg[rx_enable_pos];
    end
  end

  // Helper: running cycles since last rx divider tick, whether or not rx is enabled
  logic [11:0] rx_gap_reg;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_gap_reg <= 12'h000;
    end else if (run) begin
      rx_gap_reg <= rx_div_tick ? 12'h000 : rx_gap_reg + 12'h001;
    end
  end

  property p_stop_halts;
    @(posedge clk_in) disable iff (!rst_n_in)
    (mode_in == stop_mode) |=> !tx_tick_out && !rx_sample_tick_out;
  endproperty
  a_stop_halts: assert property (p_stop_halts) else $error("Tick during stop");
  property p_stop_freeze;
    @(posedge clk_in) disable iff (!rst_n_in)
    (mode_in == stop_mode) |=> $stable(tx_os_reg) && $stable(tx_div_reg) && $stable(pre_cnt_reg);
  endproperty
  a_stop_freeze: assert property (p_stop_freeze) else $error("Counters moved in stop");
  property p_abort;
    @(posedge clk_in) disable iff (!rst_n_in)
    (clk_en_in && mode_in == stop_mode && !stop_d_reg && rx_busy_in) |=> rx_abort_out;
  endproperty
  a_abort: assert property (p_abort) else $error("Rx not aborted on stop");
  property p_pre_div1;
    @(posedge clk_in) disable iff (!rst_n_in)
    (run && pre_sel == 2'b00) |-> pre_tick;
  endproperty
  a_pre_div1: assert property (p_pre_div1) else $error("Ratio 1 prescale wrong");
  property p_pre_13;
    @(posedge clk_in) disable iff (!rst_n_in)
    (run && pre_sel == 2'b11 && pre_cnt_reg == 4'hc) |=> pre_cnt_reg == 4'h0;
  endproperty
  a_pre_13: assert property (p_pre_13) else $error("Ratio 13 prescale wrong");
  property p_rx_div_bound;
    @(posedge clk_in) disable iff (!rst_n_in)
    (run && rx_div_tick) |=> rx_div_reg == 7'h00;
  endproperty
  a_rx_div_bound: assert property (p_rx_div_bound) else $error("Rx divider overrun");
  property p_rx_gap;
    @(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |-> rx_gap_reg < 12'h680;
  endproperty
  a_rx_gap: assert property (p_rx_gap) else $error("Rx sample gap too long");
  property p_wait_wake;
    @(posedge clk_in) disable iff (!rst_n_in)
    (clk_en_in && mode_in == wait_mode && |(stat_next & mask_next)) |=> wake_out && irq_out;
  endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("No wake in wait");
  property p_disable;
    @(posedge clk_in) disable iff (!rst_n_in)
    (!tx_enable_out && !rx_enable_out) |=> !tx_tick_out && !rx_sample_tick_out;
  endproperty
  a_disable: assert property (p_disable) else $error("Tick while disabled");

  // Helper: cycles since last tx bit tick
  logic [14:0] tx_gap_reg;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tx_gap_reg <= 15'h0000;
    end else if (run) begin
      tx_gap_reg <= tx_bit ? 15'h0000 : tx_gap_reg + 15'h0001;
    end
  end

  property p_tx_gap;
    @(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |-> tx_gap_reg < 15'h6800;
  endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("Tx bit gap too long");

  property p_pre_div3;
    @(posedge clk_in) disable iff (!rst_n_in)
    (run && pre_sel == 2'b01 && pre_cnt_reg == 4'h2) |=> pre_cnt_reg == 4'h0;
  endproperty
  a_pre_div3: assert property (p_pre_div3) else $error("Ratio 3 prescale wrong");

  property p_pre_div4;
    @(posedge clk_in) disable iff (!rst_n_in)
    (run && pre_sel == 2'b10 && pre_cnt_reg == 4'h3) |=> pre_cnt_reg == 4'h0;
  endproperty
  a_pre_div4: assert property (p_pre_div4) else $error("Ratio 4 prescale wrong");

  property p_pre_step;
    @(posedge clk_in) disable iff (!rst_n_in)
    (run && !pre_tick) |=> pre_cnt_reg == $past(pre_cnt_reg) + 4'h1;
  endproperty
  a_pre_step: assert property (p_pre_step) else $error("Prescaler skipped a count");

  property p_freeze_en;
    @(posedge clk_in) disable iff (!rst_n_in)
    !clk_en_in |=> $stable(rate_reg) && $stable(ctrl_reg) && $stable(stat_reg) && $stable(pre_cnt_reg)
      && $stable(rdata_out);
  endproperty
  a_freeze_en: assert property (p_freeze_en) else $error("State moved with enable low");

  property p_tx_div_step;
    @(posedge clk_in) disable iff (!rst_n_in)
    (run && pre_tick && !tx_div_tick) |=> tx_div_reg == $past(tx_div_reg) + 7'h01;
  endproperty
  a_tx_div_step: assert property (p_tx_div_step) else $error("Tx divider skipped a count");

  property p_tx_div_wrap;
    @(posedge clk_in) disable iff (!rst_n_in)
    (run && tx_div_tick) |=> tx_div_reg == 7'h00;
  endproperty
  a_tx_div_wrap: assert property (p_tx_div_wrap) else $error("Tx divider did not wrap");

  property p_rx_div_step;
    @(posedge clk_in) disable iff (!rst_n_in)
    (run && pre_tick && !rx_div_tick) |=> rx_div_reg == $past(rx_div_reg) + 7'h01;
  endproperty
  a_rx_div_step: assert property (p_rx_div_step) else $error("Rx divider skipped a count");

  property p_div_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
    (run && !pre_tick) |=> $stable(tx_div_reg) && $stable(rx_div_reg);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("Divider moved without prescale tick");

  property p_both_div;
    @(posedge clk_in) disable iff (!rst_n_in)
    (run && pre_tick) |=> (tx_div_reg != $past(tx_div_reg) || tx_div_reg == 7'h00)
      && (rx_div_reg != $past(rx_div_reg) || rx_div_reg == 7'h00);
  endproperty
  a_both_div: assert property (p_both_div) else $error("Dividers not fed together");

  property p_tx_os_step;
    @(posedge clk_in) disable iff (!rst_n_in)
    (run && tx_div_tick) |=> tx_os_reg == $past(tx_os_reg) + 4'h1;
  endproperty
  a_tx_os_step: assert property (p_tx_os_step) else $error("Tx sixteenth count wrong");

  property p_tx_os_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
    (run && !tx_div_tick) |=> $stable(tx_os_reg);
  endproperty
  a_tx_os_hold: assert property (p_tx_os_hold) else $error("Tx sixteenth count moved");

  property p_tx_tick_src;
    @(posedge clk_in) disable iff (!rst_n_in)
    (run && tx_bit && ctrl_reg[tx_enable_pos]) |=> tx_tick_out;
  endproperty
  a_tx_tick_src: assert property (p_tx_tick_src) else $error("Tx tick missing");

  property p_tx_tick_single;
    @(posedge clk_in) disable iff (!rst_n_in)
    (clk_en_in && tx_tick_out) |=> !tx_tick_out;
  endproperty
  a_tx_tick_single: assert property (p_tx_tick_single) else $error("Tx tick too long");

  property p_rx_tick_src;
    @(posedge clk_in) disable iff (!rst_n_in)
    (run && rx_div_tick && ctrl_reg[rx_enable_pos]) |=> rx_sample_tick_out;
  endproperty
  a_rx_tick_src: assert property (p_rx_tick_src) else $error("Rx sample tick missing");

  property p_rx_tick_gated;
    @(posedge clk_in) disable iff (!rst_n_in)
    (clk_en_in && !ctrl_reg[rx_enable_pos]) |=> !rx_sample_tick_out;
  endproperty
  a_rx_tick_gated: assert property (p_rx_tick_gated) else $error("Rx tick while rx off");

  property p_wait_count;
    @(posedge clk_in) disable iff (!rst_n_in)
    (clk_en_in && mode_in == wait_mode && !pre_tick) |=> pre_cnt_reg == $past(pre_cnt_reg) + 4'h1;
  endproperty
  a_wait_count: assert property (p_wait_count) else $error("Prescaler stalled in wait");

  property p_wait_ticks;
    @(posedge clk_in) disable iff (!rst_n_in)
    (clk_en_in && mode_in == wait_mode && rx_div_tick && ctrl_reg[rx_enable_pos]) |=> rx_sample_tick_out;
  endproperty
  a_wait_ticks: assert property (p_wait_ticks) else $error("Rx tick lost in wait");

  property p_stop_rx_freeze;
    @(posedge clk_in) disable iff (!rst_n_in)
    (mode_in == stop_mode) |=> $stable(rx_div_reg);
  endproperty
  a_stop_rx_freeze: assert property (p_stop_rx_freeze) else $error("Rx divider moved in stop");

  property p_stop_status;
    @(posedge clk_in) disable iff (!rst_n_in)
    (clk_en_in && req_in.rd && req_in.addr == gen_status_addr) |=> rdata_out[1] == $past(mode_in == stop_mode);
  endproperty
  a_stop_status: assert property (p_stop_status) else $error("Stopped flag wrong");

  property p_abort_idle;
    @(posedge clk_in) disable iff (!rst_n_in)
    (clk_en_in && !rx_busy_in) |=> !rx_abort_out;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("Abort with idle receiver");

  property p_abort_once;
    @(posedge clk_in) disable iff (!rst_n_in)
    (clk_en_in && rx_abort_out) |=> !rx_abort_out;
  endproperty
  a_abort_once: assert property (p_abort_once) else $error("Abort pulse too long");

  property p_rdata_idle;
    @(posedge clk_in) disable iff (!rst_n_in)
    (clk_en_in && !req_in.rd) |=> rdata_out == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data without read");

  property p_irq_level;
    @(posedge clk_in) disable iff (!rst_n_in)
    clk_en_in |=> irq_out == |(stat_reg & mask_reg);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("Interrupt level wrong");

  property p_wake_wait_only;
    @(posedge clk_in) disable iff (!rst_n_in)
    (clk_en_in && mode_in != wait_mode) |=> !wake_out;
  endproperty
  a_wake_wait_only: assert property (p_wake_wait_only) else $error("Wake outside wait");

  property p_enable_mirror;
    @(posedge clk_in) disable iff (!rst_n_in)
    clk_en_in |=> (tx_enable_out == ctrl_reg[tx_enable_pos]) && (rx_enable_out == ctrl_reg[rx_enable_pos]);
  endproperty
  a_enable_mirror: assert property (p_enable_mirror) else $error("Enable outputs wrong");
endmodule

// [rtl/baud_gen_pkg.sv]
// Package for the serial baud generator: offsets, field positions, reset values, types.
// Assumes a byte-wide register port clocked by the processor clock.
package baud_gen_pkg;
  localparam logic [3:0] rate_reg_addr = 4'h0d;
  localparam logic [3:0] ctrl_two_addr = 4'h0f;
  localparam logic [3:0] irq_status_addr = 4'h01;
  localparam logic [3:0] irq_mask_addr = 4'h02;
  localparam logic [3:0] gen_status_addr = 4'h03;
  localparam int prescale_sel_lo_pos = 6;
  localparam int tx_rate_sel_pos = 3;
  localparam int rx_rate_sel_pos = 0;
  localparam int tx_enable_pos = 3;
  localparam int rx_enable_pos = 2;
  localparam logic [7:0] rate_reg_reset = 8'h00;
  localparam logic [7:0] ctrl_two_reset = 8'h00;
  localparam logic [7:0] irq_reset = 8'h00;
  localparam logic [3:0] ratio_1 = 4'h0;
  localparam logic [3:0] ratio_3 = 4'h2;
  localparam logic [3:0] ratio_4 = 4'h3;
  localparam logic [3:0] ratio_13 = 4'hc;
  localparam logic [3:0] rx_oversample_last = 4'hf;
  localparam int clk_freq_hz = 10000000;
  localparam int clk_period_ns = 1000000000 / clk_freq_hz;
  typedef enum logic [1:0] {run_mode, wait_mode, stop_mode} power_mode_e;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage

// [testbench/serial_partner.sv]
// Behavioural far-side serial device: counts the generator's ticks through one character.
// Assumes the baud generator's ticks and abort pulse on the same processor clock.
`timescale 1ns/10ps
module serial_partner (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic tx_tick_in,
  input wire logic rx_sample_tick_in,
  input wire logic rx_abort_in,
  output logic tx_busy_out,
  output logic rx_busy_out
);
  logic [7:0] rx_cnt_reg;
  logic [3:0] tx_cnt_reg;
  assign tx_busy_out = (tx_cnt_reg != 4'h0);
  assign rx_busy_out = (rx_cnt_reg != 8'h00);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_cnt_reg <= 8'h00;
      tx_cnt_reg <= 4'h0;
    end else if (start_in) begin
      rx_cnt_reg <= 8'ha0;
      tx_cnt_reg <= 4'ha;
    end else begin
      if (rx_abort_in) rx_cnt_reg <= 8'h00;
      else if (rx_sample_tick_in && rx_busy_out) rx_cnt_reg <= rx_cnt_reg - 8'h01;
      if (tx_tick_in && tx_busy_out) tx_cnt_reg <= tx_cnt_reg - 4'h1;
    end
  end
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the baud generator: rates, stop, wait, enables and interrupts.
// Assumes the serial partner model and the baud generator package.
`timescale 1ns/10ps
module testbench;
  import baud_gen_pkg::*;
  typedef struct {logic [7:0] rate; int rxp; int txp;} row_s;
  row_s rows [4] = '{'{8'h4a, 12, 96}, '{8'h81, 8, 64}, '{8'hc0, 13, 208}, '{8'h3b, 8, 2048}};
  logic clk_in = 0, rst_n_in = 0, start = 0, clk_en = 1, tx_busy, rx_busy;
  reg_req_s req_in = '0;
  power_mode_e mode_in = run_mode;
  logic [7:0] rdata_out, d;
  logic tx_tick_out, rx_sample_tick_out, rx_abort_out, tx_enable_out, rx_enable_out, irq_out, wake_out;
  int n_errors = 0, samples_checked = 0, c, i;
  always #50 clk_in = ~clk_in;
  baud_gen uut (.clk_in, .rst_n_in, .clk_en_in(clk_en), .req_in, .mode_in, .rx_busy_in(rx_busy),
    .tx_busy_in(tx_busy), .rdata_out, .tx_tick_out, .rx_sample_tick_out, .rx_abort_out,
    .tx_enable_out, .rx_enable_out, .irq_out, .wake_out);
  serial_partner partner (.clk_in, .rst_n_in, .start_in(start), .tx_tick_in(tx_tick_out),
    .rx_sample_tick_in(rx_sample_tick_out), .rx_abort_in(rx_abort_out), .tx_busy_out(tx_busy),
    .rx_busy_out(rx_busy));
  task finish_test;
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in) req_in <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_in) req_in.wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_in) req_in <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_in) req_in.rd <= 1'b0;
    @(negedge clk_in) v = rdata_out;
  endtask
  task sync(input bit rx);
    int k;
    k = 0;
    do begin
      @(negedge clk_in);
      if (++k > 3000) begin
        n_errors++;
        finish_test();
      end
    end while ((rx ? rx_sample_tick_out : tx_tick_out) !== 1'b1);
  endtask
  task gap(input bit rx, output int g);
    longint t0;
    sync(rx);
    sync(rx);
    t0 = $time;
    sync(rx);
    g = int'(($time - t0) / clk_period_ns);
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    chk(16'(irq_out), 16'h0000);
    rst_n_in <= 1'b1;
    rd(rate_reg_addr, d); chk(16'(d), 16'(rate_reg_reset));
    rd(ctrl_two_addr, d); chk(16'(d), 16'(ctrl_two_reset));
    rd(4'h5, d); chk(16'(d), 16'h0000);
    wr(ctrl_two_addr, 8'h0c);
    @(negedge clk_in) chk(16'({tx_enable_out, rx_enable_out}), 16'h0003);
    foreach (rows[k]) begin
      wr(rate_reg_addr, rows[k].rate);
      rd(rate_reg_addr, d); chk(16'(d), 16'(rows[k].rate));
      gap(1'b1, c); chk(16'(c), 16'(rows[k].rxp));
      gap(1'b0, c); chk(16'(c), 16'(rows[k].txp));
    end
    wr(rate_reg_addr, 8'h00);
    gap(1'b0, c);
    @(posedge clk_in) mode_in <= stop_mode;
    repeat (10) @(posedge clk_in);
    @(negedge clk_in) chk(16'({tx_tick_out, rx_sample_tick_out}), 16'h0000);
    repeat (10) @(posedge clk_in);
    mode_in <= run_mode;
    sync(1'b0);
    gap(1'b0, c); chk(16'(c), 16'h0010);
    @(posedge clk_in) start <= 1'b1;
    @(posedge clk_in) start <= 1'b0;
    repeat (3) @(posedge clk_in);
    mode_in <= stop_mode;
    for (i = 0; i < 5 && rx_abort_out !== 1'b1; i++) @(negedge clk_in);
    chk(16'(rx_abort_out), 16'h0001);
    repeat (3) @(negedge clk_in);
    chk(16'({tx_busy, rx_busy}), 16'h0002);
    @(posedge clk_in) mode_in <= wait_mode;
    gap(1'b0, c); chk(16'(c), 16'h0010);
    for (i = 0; i < 400 && tx_busy !== 1'b0; i++) @(negedge clk_in);
    chk(16'(tx_busy), 16'h0000);
    wr(irq_mask_addr, 8'h00);
    @(negedge clk_in) chk(16'({irq_out, wake_out}), 16'h0000);
    wr(irq_mask_addr, 8'h01);
    repeat (2) @(negedge clk_in);
    chk(16'({irq_out, wake_out}), 16'h0003);
    @(posedge clk_in) mode_in <= run_mode;
    wr(ctrl_two_addr, 8'h00);
    @(negedge clk_in) chk(16'({tx_enable_out, rx_enable_out}), 16'h0000);
    wr(irq_status_addr, 8'h07);
    rd(irq_status_addr, d); chk(16'(d), 16'h0000);
    @(negedge clk_in) chk(16'({irq_out, wake_out, rx_sample_tick_out}), 16'h0000);
    @(posedge clk_in) clk_en <= 1'b0;
    wr(ctrl_two_addr, 8'h0c);
    @(posedge clk_in) clk_en <= 1'b1;
    rd(ctrl_two_addr, d); chk(16'(d), 16'h0000);
    finish_test();
  end
endmodule
